//--- testbench/lsi_monitor.sv
`timescale 1ns/1ps
module lsi_monitor #(parameter BTN_CYC = 20, parameter LINK_CYC = 50) (
  // Clock and inputs
  input wire REF_CLK, RESET, SET_BUTTON, CONFIG_MODE, LOCAL_BUS_ERR, LINK_UP,
  input wire PACKET_OK, IS_MASTER, MULTI_NODE, OVERLOAD, FW_UPDATE, STICK_WRITE,
  input wire SER_TX_ACTIVE, HOST_RD,
  input wire signed [7:0] PARENT_DBM,
  // Outputs
  input wire signed [7:0] HOST_DBM,
  input wire HOST_VALID, FAULT_LAMP, TX_LAMP, LINK_RELAY, READIN_START,
  input wire [3:0] BAR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  reg [7:0] held_ff, quiet_ff;
  wire dark = !LINK_UP || CONFIG_MODE || OVERLOAD;
  wire run = FW_UPDATE || STICK_WRITE;
  // Saturate so a long press or a long silence never wraps back to zero
  always @(posedge REF_CLK) begin
    held_ff <= (RESET || !SET_BUTTON) ? 8'h0 : held_ff + {7'h0, ~&held_ff};
    quiet_ff <= (RESET || PACKET_OK) ? 8'h0 : quiet_ff + {7'h0, ~&quiet_ff};
  end
  sequence s_host_req;
    HOST_RD && IS_MASTER;
  endsequence
  // Link loss reaches the bar through the link state, one cycle later
  sequence s_link_gone;
    !LINK_UP ##1 !run;
  endsequence
  a_start_held: assert property (READIN_START |-> held_ff >= BTN_CYC)
    else $error("read-in started without a long press");
  a_host_answer: assert property (s_host_req |=> HOST_VALID && HOST_DBM == $past(PARENT_DBM))
    else $error("host read not answered with parent strength");
  a_relay_timeout: assert property (quiet_ff >= LINK_CYC + 3 |-> !LINK_RELAY)
    else $error("relay held without packets");
  a_relay_drop: assert property (!LINK_UP |-> ##2 !LINK_RELAY)
    else $error("relay held after link loss");
  a_tx_lamp: assert property (SER_TX_ACTIVE |=> TX_LAMP)
    else $error("transmit lamp dark while sending");
  a_fault_steady: assert property (LOCAL_BUS_ERR [*2] |-> FAULT_LAMP)
    else $error("fault lamp not lit on local bus error");
  a_bar_dark: assert property ((CONFIG_MODE || OVERLOAD) && !run |=> BAR == 4'h0)
    else $error("bar lit while dark expected");
  a_bar_unlinked: assert property (s_link_gone |=> BAR == 4'h0)
    else $error("bar lit after link loss");
  a_master_yellow: assert property (IS_MASTER && MULTI_NODE && LINK_RELAY && !dark && !run
    |=> BAR == 4'h1)
    else $error("master in network shows more than yellow");
  a_bar_running: assert property (run |=> $onehot(BAR))
    else $error("running bar not one segment");
endmodule // lsi_monitor

bind lsi_status lsi_monitor #(.BTN_CYC(BTN_CYC), .LINK_CYC(LINK_CYC)) mon_u (.*);

//--- testbench/lsi_peer.sv
`timescale 1ns/1ps
// Far side: radio peer sending packets and a serial host polling strength
module lsi_peer (
  // Clock and scenario control
  input wire REF_CLK,
  input wire link_en,
  input wire pkt_en,
  // Toward the block
  output reg LINK_UP = 1'b0,
  output reg PACKET_OK = 1'b0,
  output reg HOST_RD = 1'b0
);
  reg [3:0] cnt_ff = 4'h0;
  always @(posedge REF_CLK) begin
    cnt_ff <= cnt_ff + 4'h1;
    LINK_UP <= link_en;
    // A peer whose link is gone cannot deliver packets
    PACKET_OK <= link_en && pkt_en && cnt_ff[2:0] == 3'h0;
    HOST_RD <= cnt_ff == 4'h5;
  end
endmodule // lsi_peer

//--- testbench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
  $display("FAIL %s expected %0h seen %0h", n, e, s); end end
module tb;
  reg REF_CLK = 1'b0, RESET = 1'b1, CE = 1'b1, SET_BUTTON = 1'b0, MODE_PLC = 1'b0;
  reg CONFIG_MODE = 1'b0, CYCLIC_DATA = 1'b0, READIN_DONE = 1'b0, DUP_SLOT_ADDR = 1'b0;
  reg MISSING_INPUT = 1'b0, MISSING_OUTPUT = 1'b0, STATION_CHANGED = 1'b0;
  reg NO_MODBUS = 1'b0, LOCAL_BUS_ERR = 1'b0, IS_MASTER = 1'b0, MULTI_NODE = 1'b0;
  reg OVERLOAD = 1'b0, FW_UPDATE = 1'b0, STICK_WRITE = 1'b0;
  reg SER_TX_ACTIVE = 1'b0, SER_RX_ACTIVE = 1'b0, link_en = 1'b0, pkt_en = 1'b0;
  reg [1:0] DATA_RATE = 2'h0;
  reg signed [7:0] PARENT_DBM = 8'sh0;
  reg [3:0] acc;
  wire LINK_UP, PACKET_OK, HOST_RD, HOST_VALID, BUS_ACTIVITY_LAMP, FAULT_LAMP;
  wire TX_LAMP, RX_LAMP, LINK_RELAY, READIN_START;
  wire signed [7:0] HOST_DBM;
  wire [3:0] BAR;
  integer err_count = 0, n_checks = 0, seed = 32'h2a86, cyc = 0, n_start = 0, i, k;
  integer ones, chg, v;
  always #12.5 REF_CLK = ~REF_CLK;
  lsi_status #(.BTN_CYC(20), .LINK_CYC(50), .STEP_CYC(4), .SLOW_HALF(6),
    .FAST_HALF(3)) dut_u (.*);
  lsi_peer peer_u (.*);
  ////////////////////////////////////////////////////////////////////////////////
  function [3:0] exp_bar(input m, input mn, input [1:0] r, input signed [7:0] d);
    integer sh;
    begin
      sh = 5 * r;
      if (m && mn) exp_bar = 4'h1;
      else if (d >= -75 + sh) exp_bar = 4'hf;
      else if (d >= -85 + sh) exp_bar = 4'h7;
      else if (d >= -95 + sh) exp_bar = 4'h3;
      else exp_bar = 4'h1;
    end
  endfunction
  task tick(input integer n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // Window of two slow periods: an equal on/off wave is high in half the samples
  task sample(input sel);
    integer p;
    begin
      ones = 0;
      chg = 0;
      p = sel ? BUS_ACTIVITY_LAMP : FAULT_LAMP;
      repeat (24) begin
        @(posedge REF_CLK);
        #1 v = sel ? BUS_ACTIVITY_LAMP : FAULT_LAMP;
        ones = ones + v;
        chg = chg + (v != p);
        p = v;
      end
    end
  endtask
  task stop_test;
    begin
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge REF_CLK) begin
    cyc = cyc + 1;
    if (READIN_START === 1'b1) n_start = n_start + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    RESET <= 1'b0;
    link_en <= 1'b1;
    pkt_en <= 1'b1;
    #1 `CHK("OUTS", 10'h0, {BAR, BUS_ACTIVITY_LAMP, FAULT_LAMP, TX_LAMP, RX_LAMP, LINK_RELAY, READIN_START})
    tick(20);
    #1 `CHK("LINK_RELAY", 1'b1, LINK_RELAY)
    // First 24 passes sit on each threshold and one below it, at every rate
    for (i = 0; i < 224; i = i + 1) begin
      tick(1);
      if (i < 24) begin
        DATA_RATE <= i[1:0];
        PARENT_DBM <= 8'(-75 - 10 * ((i >> 2) % 3) + 5 * i[1:0] - i / 12);
      end else begin
        {DATA_RATE, IS_MASTER, MULTI_NODE, SER_TX_ACTIVE, SER_RX_ACTIVE, MODE_PLC, NO_MODBUS,
          DUP_SLOT_ADDR, MISSING_INPUT, MISSING_OUTPUT, STATION_CHANGED} <= 12'($random(seed));
        PARENT_DBM <= 8'(-110 + ($random(seed) & 63));
      end
      tick(2);
      #1 `CHK("BAR", exp_bar(IS_MASTER, MULTI_NODE, DATA_RATE, PARENT_DBM), BAR)
      `CHK("TX_LAMP", SER_TX_ACTIVE, TX_LAMP)
      `CHK("RX_LAMP", SER_RX_ACTIVE, RX_LAMP)
    end
    tick(1);
    {IS_MASTER, MULTI_NODE, MODE_PLC, NO_MODBUS, DUP_SLOT_ADDR, MISSING_INPUT, MISSING_OUTPUT,
      STATION_CHANGED} <= 8'h0;
    LOCAL_BUS_ERR <= 1'b1;
    tick(3);
    #1 `CHK("FAULT_LAMP", 1'b1, FAULT_LAMP)
    LOCAL_BUS_ERR <= 1'b0;
    tick(3);
    #1 `CHK("FAULT_LAMP", 1'b0, FAULT_LAMP)
    // I/O mode with a missing input, then PLC mode without Modbus
    for (k = 0; k < 2; k = k + 1) begin
      tick(1);
      {MODE_PLC, NO_MODBUS, MISSING_INPUT} <= k ? 3'h6 : 3'h1;
      tick(2);
      #1 sample(0);
      `CHK("FAULT_SLOW_ON", 12, ones)
      `CHK("FAULT_SLOW_EDGES", 4, chg)
    end
    tick(1);
    {MODE_PLC, NO_MODBUS, MISSING_INPUT} <= 3'h0;
    for (k = 0; k < 2; k = k + 1) begin
      tick(1);
      {CONFIG_MODE, OVERLOAD} <= k ? 2'h1 : 2'h2;
      tick(3);
      #1 `CHK("BAR", 4'h0, BAR)
      if (k == 0) begin
        sample(1);
        `CHK("BUS_FLASH_ON", 12, ones)
        `CHK("BUS_FLASH_EDGES", 4, chg)
      end
    end
    // Each running pattern must visit every segment
    for (k = 0; k < 2; k = k + 1) begin
      tick(1);
      {CONFIG_MODE, OVERLOAD} <= 2'h0;
      {FW_UPDATE, STICK_WRITE} <= k ? 2'h1 : 2'h2;
      acc = 4'h0;
      for (i = 0; i < 24; i = i + 1) begin
        tick(1);
        #1 acc = acc | BAR;
      end
      `CHK("BAR_RUN", 4'hf, acc)
    end
    tick(1);
    {FW_UPDATE, STICK_WRITE} <= 2'h0;
    CYCLIC_DATA <= 1'b1;
    // A short press must be ignored, a long one starts read-in once
    for (k = 0; k < 2; k = k + 1) begin
      tick(1);
      SET_BUTTON <= 1'b1;
      n_start = 0;
      tick(k ? 30 : 10);
      SET_BUTTON <= 1'b0;
      tick(4);
      #1 `CHK("READIN_START", k, n_start)
    end
    // Read-in in progress: the bus lamp flashes even with cyclic data
    sample(1);
    `CHK("READIN_FLASH", 12, ones)
    tick(1);
    READIN_DONE <= 1'b1;
    tick(1);
    READIN_DONE <= 1'b0;
    tick(3);
    #1 `CHK("BUS_LAMP", 1'b1, BUS_ACTIVITY_LAMP)
    CYCLIC_DATA <= 1'b0;
    tick(3);
    #1 `CHK("BUS_LAMP", 1'b0, BUS_ACTIVITY_LAMP)
    pkt_en <= 1'b0;
    tick(60);
    #1 `CHK("LINK_RELAY", 1'b0, LINK_RELAY)
    sample(0);
    `CHK("FAULT_FAST_EDGES", 8, chg)
    `CHK("FAULT_FAST_ON", 12, ones)
    // Enable low must freeze the flashing lamp
    tick(1);
    CE <= 1'b0;
    #1 v = FAULT_LAMP;
    repeat (10) begin
      tick(1);
      #1 `CHK("CE_HOLD", v, FAULT_LAMP)
    end
    tick(1);
    CE <= 1'b1;
    pkt_en <= 1'b1;
    tick(20);
    #1 `CHK("LINK_RELAY", 1'b1, LINK_RELAY)
    link_en <= 1'b0;
    tick(4);
    #1 `CHK("LINK_RELAY", 1'b0, LINK_RELAY)
    `CHK("BAR", 4'h0, BAR)
    stop_test;
  end
endmodule // tb

//--- verilog/lsi_defs.vh
`ifndef LSI_DEFS_VH
`define LSI_DEFS_VH

// Clock rate and derived counts
`define LSI_CLK_HZ 40000000
`define LSI_SLOW_HZ_X10 14
`define LSI_FAST_HZ_X10 28
// Half period of a flash in cycles: clk / (2 * f)
`define LSI_SLOW_HALF ((`LSI_CLK_HZ * 10) / (2 * `LSI_SLOW_HZ_X10))
`define LSI_FAST_HALF ((`LSI_CLK_HZ * 10) / (2 * `LSI_FAST_HZ_X10))
`define LSI_BTN_MS 1000
`define LSI_BTN_CYC ((`LSI_CLK_HZ / 1000) * `LSI_BTN_MS)
`define LSI_LINK_TMO_S 10
`define LSI_LINK_CYC (`LSI_CLK_HZ * `LSI_LINK_TMO_S)
`define LSI_RUN_STEP_CYC (`LSI_CLK_HZ / 8)

// Strength thresholds, dBm, at the 16k rate
`define LSI_TH_EXC (-75)
`define LSI_TH_VGOOD (-85)
`define LSI_TH_GOOD (-95)
// Threshold rise per rate step: 16k, 125k, 250k, 500k
`define LSI_RATE_STEP 5

// Data rate codes
`define LSI_RATE_16K 2'h0
`define LSI_RATE_125K 2'h1
`define LSI_RATE_250K 2'h2
`define LSI_RATE_500K 2'h3

// Bar patterns, bit 0 is the yellow (bottom) segment
`define LSI_BAR_OFF 4'h0
`define LSI_BAR_LOW 4'h1
`define LSI_BAR_GOOD 4'h3
`define LSI_BAR_VGOOD 4'h7
`define LSI_BAR_EXC 4'hf

// Operating modes
`define LSI_MODE_IO 1'b0
`define LSI_MODE_PLC 1'b1

`endif

//--- verilog/lsi_flasher.v
`timescale 1ns/1ps
`include "lsi_defs.vh"

// Free-running square wave with equal on and off time
module lsi_flasher #(
  parameter HALF = 1000,
  parameter W = 32
) (
  // Clock and control
  input wire clk,
  input wire rst,
  input wire ce,
  // Wave
  output reg wave
);

  reg [W-1:0] cnt_ff;

  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= {W{1'b0}};
      wave <= 1'b0;
    end else if (ce) begin
      if (cnt_ff == HALF - 1) begin
        cnt_ff <= {W{1'b0}};
        wave <= ~wave;
      end else begin
        cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // lsi_flasher

//--- verilog/lsi_status.v
// Operation
// - Bus lamp: off, flash config, on cyclic
// - I/O mode faults flash fault lamp slowly
// - PLC mode faults flash fault lamp slowly
// - Link loss flashes fast; else off
// - Local bus error lights fault lamp steadily
// - Bar shows four strength classes or dark
// - Thresholds rise with configured radio rate
// - Update or stick write runs bar upward
// - Transmit lamp lit while sending serial
// - Receive lamp lit while receiving serial
// - One-second button press rereads station configuration
// - Relay follows link, drops after 10 s
// - Point-to-point: bar active on both ends
// - Master in network: yellow segment only
// - Slave shows strength of its parent
// - Master returns strength values to host
`timescale 1ns/1ps
`include "lsi_defs.vh"

module lsi_status #(
  parameter BTN_CYC = `LSI_BTN_CYC,
  parameter LINK_CYC = `LSI_LINK_CYC,
  parameter STEP_CYC = `LSI_RUN_STEP_CYC,
  parameter SLOW_HALF = `LSI_SLOW_HALF,
  parameter FAST_HALF = `LSI_FAST_HALF
) (
  // Clock, reset, enable
  input wire REF_CLK,
  input wire RESET,
  input wire CE,
  // Pins from outside
  input wire SET_BUTTON,
  // Status from module logic
  input wire MODE_PLC,
  input wire CONFIG_MODE,
  input wire CYCLIC_DATA,
  input wire READIN_DONE,
  input wire DUP_SLOT_ADDR,
  input wire MISSING_INPUT,
  input wire MISSING_OUTPUT,
  input wire STATION_CHANGED,
  input wire NO_MODBUS,
  input wire LOCAL_BUS_ERR,
  input wire LINK_UP,
  input wire PACKET_OK,
  input wire IS_MASTER,
  input wire MULTI_NODE,
  input wire [1:0] DATA_RATE,
  input wire signed [7:0] PARENT_DBM,
  input wire OVERLOAD,
  input wire FW_UPDATE,
  input wire STICK_WRITE,
  input wire SER_TX_ACTIVE,
  input wire SER_RX_ACTIVE,
  // Strength read by host
  input wire HOST_RD,
  output reg signed [7:0] HOST_DBM,
  output reg HOST_VALID,
  // Lamps and relay
  output reg BUS_ACTIVITY_LAMP,
  output reg FAULT_LAMP,
  output reg [3:0] BAR,
  output reg TX_LAMP,
  output reg RX_LAMP,
  output reg LINK_RELAY,
  output reg READIN_START
);

  //////////////////////////////////////////////////////////////////////////////
  // Button synchroniser and hold timer

  reg btn_s1_ff;
  reg btn_s2_ff;
  reg [31:0] btn_cnt_ff;
  reg btn_fired_ff;
  reg readin_ff;

  always @(posedge REF_CLK) begin
    if (RESET) begin
      btn_s1_ff <= 1'b0;
      btn_s2_ff <= 1'b0;
    end else if (CE) begin
      btn_s1_ff <= SET_BUTTON;
      btn_s2_ff <= btn_s1_ff;
    end
  end

  // One start per press: the count halts until release
  always @(posedge REF_CLK) begin
    if (RESET) begin
      btn_cnt_ff <= 32'h0;
      btn_fired_ff <= 1'b0;
      READIN_START <= 1'b0;
      readin_ff <= 1'b0;
    end else if (CE) begin
      READIN_START <= 1'b0;
      if (!btn_s2_ff) begin
        btn_cnt_ff <= 32'h0;
        btn_fired_ff <= 1'b0;
      end else if (!btn_fired_ff) begin
        if (btn_cnt_ff == BTN_CYC - 1) begin
          btn_fired_ff <= 1'b1;
          READIN_START <= 1'b1;
        end else begin
          btn_cnt_ff <= btn_cnt_ff + 32'h1;
        end
      end
      // Start outranks done arriving in the same cycle
      if (btn_s2_ff && !btn_fired_ff && btn_cnt_ff == BTN_CYC - 1) begin
        readin_ff <= 1'b1;
      end else if (READIN_DONE) begin
        readin_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash generators

  wire slow_wave;
  wire fast_wave;

  lsi_flasher #(.HALF(SLOW_HALF), .W(32)) u_slow (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .wave(slow_wave)
  );

  lsi_flasher #(.HALF(FAST_HALF), .W(32)) u_fast (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .wave(fast_wave)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Link relay timeout

  reg [31:0] link_cnt_ff;
  reg link_ok_ff;

  // Any good packet restarts the 10 s window
  always @(posedge REF_CLK) begin
    if (RESET) begin
      link_cnt_ff <= 32'h0;
      link_ok_ff <= 1'b0;
    end else if (CE) begin
      if (PACKET_OK) begin
        link_cnt_ff <= 32'h0;
        link_ok_ff <= LINK_UP;
      end else if (link_cnt_ff == LINK_CYC - 1) begin
        link_ok_ff <= 1'b0;
      end else begin
        link_cnt_ff <= link_cnt_ff + 32'h1;
        if (!LINK_UP) begin
          link_ok_ff <= 1'b0;
        end else if (link_cnt_ff == 32'h0) begin
          link_ok_ff <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strength classification

  reg signed [8:0] shift;
  reg signed [8:0] th_exc;
  reg signed [8:0] th_vgood;
  reg signed [8:0] th_good;
  reg signed [8:0] dbm;
  reg [3:0] strength_bar;

  // Sized copies keep the threshold sums at the nine-bit width of dbm
  localparam signed [8:0] TH_EXC = `LSI_TH_EXC;
  localparam signed [8:0] TH_VGOOD = `LSI_TH_VGOOD;
  localparam signed [8:0] TH_GOOD = `LSI_TH_GOOD;
  localparam signed [8:0] SHIFT_1 = `LSI_RATE_STEP;
  localparam signed [8:0] SHIFT_2 = 2 * `LSI_RATE_STEP;
  localparam signed [8:0] SHIFT_3 = 3 * `LSI_RATE_STEP;

  // Each rate step lifts all thresholds; 500k ends 15 dB above 16k
  always @* begin
    case (DATA_RATE)
      `LSI_RATE_16K: shift = 9'sd0;
      `LSI_RATE_125K: shift = SHIFT_1;
      `LSI_RATE_250K: shift = SHIFT_2;
      default: shift = SHIFT_3;
    endcase
    th_exc = TH_EXC + shift;
    th_vgood = TH_VGOOD + shift;
    th_good = TH_GOOD + shift;
    dbm = {PARENT_DBM[7], PARENT_DBM};
    if (dbm >= th_exc) begin
      strength_bar = `LSI_BAR_EXC;
    end else if (dbm >= th_vgood) begin
      strength_bar = `LSI_BAR_VGOOD;
    end else if (dbm >= th_good) begin
      strength_bar = `LSI_BAR_GOOD;
    end else begin
      strength_bar = `LSI_BAR_LOW;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Running bar sequence

  reg [31:0] step_cnt_ff;
  reg [1:0] run_pos_ff;
  wire running = FW_UPDATE | STICK_WRITE;

  always @(posedge REF_CLK) begin
    if (RESET) begin
      step_cnt_ff <= 32'h0;
      run_pos_ff <= 2'h0;
    end else if (CE) begin
      if (!running) begin
        step_cnt_ff <= 32'h0;
        run_pos_ff <= 2'h0;
      end else if (step_cnt_ff == STEP_CYC - 1) begin
        step_cnt_ff <= 32'h0;
        run_pos_ff <= run_pos_ff + 2'h1;
      end else begin
        step_cnt_ff <= step_cnt_ff + 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lamp selection

  reg nxt_bus;
  reg nxt_fault;
  reg [3:0] nxt_bar;
  reg slow_fault;

  always @* begin
    // Bus lamp; read-in counts as configuration
    if (CONFIG_MODE || readin_ff) begin
      nxt_bus = slow_wave;
    end else if (CYCLIC_DATA) begin
      nxt_bus = 1'b1;
    end else begin
      nxt_bus = 1'b0;
    end
    if (MODE_PLC == `LSI_MODE_PLC) begin
      slow_fault = DUP_SLOT_ADDR | STATION_CHANGED | NO_MODBUS;
    end else begin
      slow_fault = DUP_SLOT_ADDR | MISSING_INPUT | MISSING_OUTPUT |
                   STATION_CHANGED;
    end
    // Steady outranks fast outranks slow: the graver fault shows
    if (LOCAL_BUS_ERR) begin
      nxt_fault = 1'b1;
    end else if (!link_ok_ff) begin
      nxt_fault = fast_wave;
    end else if (slow_fault) begin
      nxt_fault = slow_wave;
    end else begin
      nxt_fault = 1'b0;
    end
    if (running) begin
      nxt_bar = 4'h1 << run_pos_ff;
    end else if (!link_ok_ff || CONFIG_MODE || OVERLOAD) begin
      nxt_bar = `LSI_BAR_OFF;
    end else if (IS_MASTER && MULTI_NODE) begin
      nxt_bar = `LSI_BAR_LOW;
    end else begin
      nxt_bar = strength_bar;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always @(posedge REF_CLK) begin
    if (RESET) begin
      BUS_ACTIVITY_LAMP <= 1'b0;
      FAULT_LAMP <= 1'b0;
      BAR <= `LSI_BAR_OFF;
      TX_LAMP <= 1'b0;
      RX_LAMP <= 1'b0;
      LINK_RELAY <= 1'b0;
      HOST_DBM <= 8'sh0;
      HOST_VALID <= 1'b0;
    end else if (CE) begin
      BUS_ACTIVITY_LAMP <= nxt_bus;
      FAULT_LAMP <= nxt_fault;
      BAR <= nxt_bar;
      TX_LAMP <= SER_TX_ACTIVE;
      RX_LAMP <= SER_RX_ACTIVE;
      LINK_RELAY <= link_ok_ff;
      // Only the master answers strength reads
      HOST_VALID <= HOST_RD & IS_MASTER;
      if (HOST_RD && IS_MASTER) begin
        HOST_DBM <= PARENT_DBM;
      end
    end
  end

endmodule // lsi_status
